/* hdl/dma_pkg.sv */
// Functional notes
// - ten channels, all copy, all but 5 and 6 in multi config also fly-by; channels 3-6 also accept external requests
// - fly-by never captures data, only drives memory address and steers the bus
// - copy reads a word into a holding register, then writes it out
// - channel change costs six save, one switch, six load cycles
// - parallel config: 1 rx, 2 tx, 3-6 parallel either way, 7-10 serial
// - multi config: 3 rx, 4 tx fifo; 5 and 6 copy only
// - three-bit multi_interface config field selects the channel assignment
// - reduced variant: channels 3 and 4 are external requests 1 and 2
// - channel idles until pointer set and enable bit written
// - descriptor is two words fly-by, four words copy, from the pointer onward
// - wrap clear: next descriptor follows the current one
// - wrap set: return to the address in the descriptor pointer
// - interrupt flag on normal close interrupts even with completion enable off
// - last flag pulses frame end to the attached peripheral
// - fly-by sets full after filling, clears after emptying, never the reverse
// - copy starts only when the full flag is one
// - fly-by read accepts a source address on any byte
// - length field counts up to 65535 bytes
// - mode field: 00 fly-by write, 01 fly-by read, 10 copy, 11 reserved
// - enable bit 31 starts fetching the first descriptor
// - fly-by write stores the received byte count into the length field
package dma_pkg;
  localparam int          NUM_CH        = 10;
  localparam logic [2:0]  SAVE_CYCLES   = 3'd6;
  localparam logic [2:0]  SWITCH_CYCLES = 3'd1;
  localparam logic [2:0]  LOAD_CYCLES   = 3'd6;
  // register map, per channel stride 0x20
  localparam logic [4:0]  OFF_BDP       = 5'h00;
  localparam logic [4:0]  OFF_CTRL      = 5'h10;
  localparam logic [4:0]  OFF_STAT      = 5'h14;
  localparam logic [3:0]  GLB_INDEX     = 4'ha;
  localparam logic [4:0]  OFF_GLB_CFG   = 5'h00;
  localparam logic [2:0]  CFG_PARALLEL  = 3'h0;
  localparam int          GLB_REDUCED   = 8;
  localparam int          CTRL_CE       = 31;
  localparam int          CTRL_MODE_LSB = 26;
  localparam int          CTRL_EXT      = 0;
  localparam int          ST_NC         = 31;
  localparam int          ST_ERR        = 30;
  localparam int          ST_SLEEP      = 29;
  localparam int          ST_NCIE       = 23;
  localparam int          ST_ERRIE      = 22;
  // descriptor word 1
  localparam int          BD_W          = 31;
  localparam int          BD_I          = 30;
  localparam int          BD_L          = 29;
  localparam int          BD_F          = 28;
  localparam int          LEN_W         = 16;
  localparam logic [1:0]  WORDS_FLY     = 2'd1;
  localparam logic [1:0]  WORDS_COPY    = 2'd3;
  localparam logic [31:0] STEP_FLY      = 32'h0000_0008;
  localparam logic [31:0] STEP_COPY     = 32'h0000_0010;
  localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;

  typedef enum logic [1:0] {
    FLYBY_WRITE = 2'b00,
    FLYBY_READ  = 2'b01,
    MEMORY_COPY = 2'b10,
    MODE_RSVD   = 2'b11
  } mode_t;

  typedef struct packed {
    logic        req;
    logic        write;
    logic        flyby;
    logic [31:0] addr;
    logic [31:0] wdata;
  } sysbus_req_t;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } sysbus_rsp_t;
endpackage : dma_pkg

/* hdl/ten_channel_descriptor_dma.sv */
`timescale 1ns/1ps
module ten_channel_descriptor_dma
  import dma_pkg::*;
(
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  output sysbus_req_t                sys_req,
  input  wire sysbus_rsp_t           sys_rsp,
  input  wire logic [NUM_CH-1:0]     dreq,
  input  wire logic [3:0]            ext_dreq,
  input  wire logic [NUM_CH-1:0]     rx_done,
  input  wire logic                  reduced_variant,
  output logic [NUM_CH-1:0]          dack,
  output logic [NUM_CH-1:0]          frame_end,
  output logic                       irq
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef enum logic [10:0] {
    S_IDLE   = 11'b000_0000_0001,
    S_SAVE   = 11'b000_0000_0010,
    S_SWITCH = 11'b000_0000_0100,
    S_LOAD   = 11'b000_0000_1000,
    S_FETCH  = 11'b000_0001_0000,
    S_CHECK  = 11'b000_0010_0000,
    S_FLY    = 11'b000_0100_0000,
    S_CRD    = 11'b000_1000_0000,
    S_CWR    = 11'b001_0000_0000,
    S_WRBACK = 11'b010_0000_0000,
    S_CLOSE  = 11'b100_0000_0000
  } fsm_t;

  typedef struct packed {
    fsm_t                    fsm;
    logic [2:0]              cnt;
    logic [3:0]              chan;
    logic [3:0]              last_chan;
    logic                    have_ctx;
    logic [NUM_CH-1:0][31:0] bdp;
    logic [NUM_CH-1:0][31:0] ctrl;
    logic [NUM_CH-1:0][31:0] cur_bd;
    logic [NUM_CH-1:0]       done;
    logic [NUM_CH-1:0]       idone;
    logic [NUM_CH-1:0]       err;
    logic [NUM_CH-1:0]       sleep;
    logic [NUM_CH-1:0]       ncie;
    logic [NUM_CH-1:0]       erie;
    logic [2:0]              mi_cfg;
    logic                    reduced;
    logic [3:0][31:0]        dw;
    logic [1:0]              widx;
    logic [31:0]             bd_addr;
    logic [31:0]             src;
    logic [31:0]             dst;
    logic [31:0]             hold;
    logic [LEN_W-1:0]        remain;
    logic [LEN_W-1:0]        moved;
    sysbus_req_t             bus;
    logic [NUM_CH-1:0]       dack;
    logic [NUM_CH-1:0]       frame_end;
    logic                    irq;
    logic                    ap_valid;
    logic                    ap_write;
    logic [11:0]             ap_addr;
    logic [31:0]             hrdata;
    logic                    hreadyout;
  } state_t;

  state_t            st_reg;
  state_t            st_next;
  logic [NUM_CH-1:0] rdy;
  logic              multi;

  assign multi = (st_reg.mi_cfg != CFG_PARALLEL);

  // ---------------------------------------------------------------
  // channel assignment check
  // ---------------------------------------------------------------
  function automatic logic mode_ok(input logic [3:0] ch, input mode_t m, input logic mi, input logic red);
    logic par;
    logic ext;
    par = (ch >= 4'd2) && (ch <= 4'd5) && !mi;
    ext = red && ((ch == 4'd2) || (ch == 4'd3));
    unique case (m)
      MEMORY_COPY: mode_ok = 1'b1;
      FLYBY_WRITE: mode_ok = (ch == 4'd0) || (ch == 4'd6) || (ch == 4'd8) || par || ext
                             || (mi && (ch == 4'd2));
      FLYBY_READ:  mode_ok = (ch == 4'd1) || (ch == 4'd7) || (ch == 4'd9) || par || ext
                             || (mi && (ch == 4'd3));
      MODE_RSVD:   mode_ok = 1'b0;
    endcase
  endfunction : mode_ok

  // ---------------------------------------------------------------
  // per-channel request
  // ---------------------------------------------------------------
  for (genvar i = 0; i < NUM_CH; i++) begin : g_rdy
    logic  hw_req;
    mode_t m;
    assign m = mode_t'(st_reg.ctrl[i][CTRL_MODE_LSB +: 2]);
    if (i >= 2 && i <= 5) begin : g_ext
      // external requests replace the peripheral one when selected
      assign hw_req = (st_reg.ctrl[i][CTRL_EXT] || (st_reg.reduced && i < 4))
                      ? ext_dreq[i-2] : dreq[i];
    end else begin : g_int
      assign hw_req = dreq[i];
    end
    assign rdy[i] = st_reg.ctrl[i][CTRL_CE] && !st_reg.sleep[i] && !st_reg.err[i]
                    && ((m == MEMORY_COPY) || hw_req);
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    logic [3:0]       pick;
    logic             found;
    logic [4:0]       idx;
    logic [3:0]       rch;
    logic [4:0]       roff;
    mode_t            m;
    logic [2:0]       step;
    logic [LEN_W-1:0] len;
    logic [31:0]      w1;
    logic [31:0]      rd;
    pick  = st_reg.last_chan;
    found = 1'b0;
    idx   = '0;
    rch   = st_reg.ap_addr[8:5];
    roff  = st_reg.ap_addr[4:0];
    m     = mode_t'(st_reg.ctrl[st_reg.chan][CTRL_MODE_LSB +: 2]);
    step  = 3'd4;
    len   = st_reg.dw[1][LEN_W-1:0];
    w1    = st_reg.dw[1];
    rd    = '0;
    st_next = st_reg;
    st_next.dack      = '0;
    st_next.frame_end = '0;
    st_next.reduced   = reduced_variant;

    // round robin starting after the last channel served
    for (int k = 1; k <= NUM_CH; k++) begin
      idx = 5'(st_reg.last_chan) + 5'(k);
      if (idx >= 5'(NUM_CH)) begin
        idx = idx - 5'(NUM_CH);
      end
      if (!found && rdy[idx[3:0]]) begin
        pick  = idx[3:0];
        found = 1'b1;
      end
    end

    // bytes this beat: up to the next word boundary, capped by length
    if (st_reg.src[1:0] != 2'd0) begin
      step = 3'd4 - {1'b0, st_reg.src[1:0]};
    end
    if (16'(step) > st_reg.remain) begin
      step = st_reg.remain[2:0];
    end

    unique case (st_reg.fsm)
      S_IDLE: begin
        if (found) begin
          st_next.chan = pick;
          st_next.cnt  = '0;
          if (st_reg.have_ctx && pick == st_reg.last_chan) begin
            st_next.fsm = S_FETCH;
          end else begin
            st_next.fsm = S_SAVE;
          end
        end
      end
      S_SAVE: begin
        st_next.cnt = st_reg.cnt + 3'd1;
        if (st_reg.cnt == SAVE_CYCLES - 3'd1) begin
          st_next.cnt = '0;
          st_next.fsm = S_SWITCH;
        end
      end
      S_SWITCH: begin
        st_next.cnt = st_reg.cnt + 3'd1;
        if (st_reg.cnt == SWITCH_CYCLES - 3'd1) begin
          st_next.cnt       = '0;
          st_next.last_chan = st_reg.chan;
          st_next.fsm       = S_LOAD;
        end
      end
      S_LOAD: begin
        st_next.cnt = st_reg.cnt + 3'd1;
        if (st_reg.cnt == LOAD_CYCLES - 3'd1) begin
          st_next.cnt      = '0;
          st_next.have_ctx = 1'b1;
          st_next.fsm      = S_FETCH;
        end
      end
      S_FETCH: begin
        if (!st_reg.bus.req) begin
          st_next.bd_addr   = st_reg.cur_bd[st_reg.chan];
          st_next.bus.req   = 1'b1;
          st_next.bus.write = 1'b0;
          st_next.bus.flyby = 1'b0;
          st_next.bus.addr  = st_reg.cur_bd[st_reg.chan] + {28'h0, st_reg.widx, 2'b00};
        end else if (sys_rsp.ack) begin
          st_next.bus.req          = 1'b0;
          st_next.dw[st_reg.widx]  = sys_rsp.rdata;
          st_next.widx             = st_reg.widx + 2'd1;
          if (st_reg.widx == ((m == MEMORY_COPY) ? WORDS_COPY : WORDS_FLY)) begin
            st_next.widx = '0;
            st_next.fsm  = S_CHECK;
          end
        end
      end
      S_CHECK: begin
        st_next.src    = st_reg.dw[0];
        st_next.dst    = st_reg.dw[2];
        st_next.remain = len;
        st_next.moved  = '0;
        st_next.fsm    = S_IDLE;
        if (!mode_ok(st_reg.chan, m, multi, st_reg.reduced)) begin
          st_next.err[st_reg.chan] = 1'b1;
        end else if (m == FLYBY_WRITE && w1[BD_F]) begin
          st_next.sleep[st_reg.chan] = 1'b1;
        end else if (m != FLYBY_WRITE && !w1[BD_F]) begin
          st_next.sleep[st_reg.chan] = 1'b1;
        end else if (m == MEMORY_COPY) begin
          st_next.fsm = S_CRD;
        end else begin
          st_next.fsm = S_FLY;
        end
      end
      S_FLY: begin
        if (!st_reg.bus.req) begin
          if (st_reg.remain == '0 || (m == FLYBY_WRITE && rx_done[st_reg.chan])) begin
            st_next.fsm = S_WRBACK;
          end else if (rdy[st_reg.chan]) begin
            // address only; the data word moves between peripheral and memory
            st_next.bus.req   = 1'b1;
            st_next.bus.flyby = 1'b1;
            st_next.bus.write = (m == FLYBY_WRITE);
            st_next.bus.addr  = st_reg.src;
            st_next.bus.wdata = '0;
          end
        end else if (sys_rsp.ack) begin
          st_next.bus.req          = 1'b0;
          st_next.dack[st_reg.chan] = 1'b1;
          st_next.src    = st_reg.src + 32'(step);
          st_next.remain = st_reg.remain - 16'(step);
          st_next.moved  = st_reg.moved + 16'(step);
        end
      end
      S_CRD: begin
        if (st_reg.remain == '0) begin
          st_next.fsm = S_WRBACK;
        end else if (!st_reg.bus.req) begin
          st_next.bus.req   = 1'b1;
          st_next.bus.flyby = 1'b0;
          st_next.bus.write = 1'b0;
          st_next.bus.addr  = st_reg.src;
        end else if (sys_rsp.ack) begin
          st_next.bus.req = 1'b0;
          st_next.hold    = sys_rsp.rdata;
          st_next.fsm     = S_CWR;
        end
      end
      S_CWR: begin
        if (!st_reg.bus.req) begin
          st_next.bus.req   = 1'b1;
          st_next.bus.write = 1'b1;
          st_next.bus.addr  = st_reg.dst;
          st_next.bus.wdata = st_reg.hold;
        end else if (sys_rsp.ack) begin
          st_next.bus.req = 1'b0;
          st_next.src     = st_reg.src + 32'(step);
          st_next.dst     = st_reg.dst + 32'(step);
          st_next.remain  = st_reg.remain - 16'(step);
          st_next.moved   = st_reg.moved + 16'(step);
          st_next.fsm     = S_CRD;
        end
      end
      S_WRBACK: begin
        if (!st_reg.bus.req) begin
          w1[BD_F]        = (m == FLYBY_WRITE);
          w1[LEN_W-1:0]   = st_reg.moved;
          st_next.bus.req   = 1'b1;
          st_next.bus.flyby = 1'b0;
          st_next.bus.write = 1'b1;
          st_next.bus.addr  = st_reg.bd_addr + WORD_BYTES;
          st_next.bus.wdata = w1;
        end else if (sys_rsp.ack) begin
          st_next.bus.req = 1'b0;
          st_next.fsm     = S_CLOSE;
        end
      end
      S_CLOSE: begin
        st_next.fsm = S_IDLE;
        if (w1[BD_W]) begin
          st_next.cur_bd[st_reg.chan] = st_reg.bdp[st_reg.chan];
        end else begin
          st_next.cur_bd[st_reg.chan] = st_reg.bd_addr
              + ((m == MEMORY_COPY) ? STEP_COPY : STEP_FLY);
        end
        st_next.frame_end[st_reg.chan] = w1[BD_L];
      end
    endcase

    // ---------------------------------------------------------------
    // register bus: write in data phase, read captured in address phase
    // ---------------------------------------------------------------
    if (st_reg.ap_valid && st_reg.ap_write) begin
      if (rch == GLB_INDEX && roff == OFF_GLB_CFG) begin
        st_next.mi_cfg = hwdata[2:0];
      end else if (rch < 4'(NUM_CH)) begin
        unique case (roff)
          OFF_BDP: st_next.bdp[rch] = hwdata;
          OFF_CTRL: begin
            st_next.ctrl[rch] = hwdata;
            if (hwdata[CTRL_CE] && !st_reg.ctrl[rch][CTRL_CE]) begin
              st_next.cur_bd[rch] = st_reg.bdp[rch];
              st_next.sleep[rch]  = 1'b0;
              st_next.err[rch]    = 1'b0;
            end
          end
          OFF_STAT: begin
            st_next.sleep[rch] = 1'b0;
            st_next.ncie[rch]  = hwdata[ST_NCIE];
            st_next.erie[rch]  = hwdata[ST_ERRIE];
            if (hwdata[ST_NC]) begin
              st_next.done[rch]  = 1'b0;
              st_next.idone[rch] = 1'b0;
            end
            if (hwdata[ST_ERR]) begin
              st_next.err[rch] = 1'b0;
            end
          end
          default: ;
        endcase
      end
    end

    // hardware events after software clears, so the set wins
    if (st_reg.fsm == S_CLOSE) begin
      st_next.done[st_reg.chan]  = 1'b1;
      // only a fresh flag sets it; a coinciding software clear of an old one still lands
      if (w1[BD_I]) begin
        st_next.idone[st_reg.chan] = 1'b1;
      end
    end
    if (st_reg.fsm == S_CHECK && !mode_ok(st_reg.chan, m, multi, st_reg.reduced)) begin
      st_next.err[st_reg.chan] = 1'b1;
    end

    // descriptor flag forces the interrupt regardless of the enable
    st_next.irq = |((st_next.done & st_next.ncie) | st_next.idone
                    | (st_next.err & st_next.erie));

    st_next.ap_valid = hsel && hready && htrans[1];
    st_next.ap_write = hwrite;
    st_next.ap_addr  = haddr[11:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      if (haddr[8:5] == GLB_INDEX && haddr[4:0] == OFF_GLB_CFG) begin
        rd = {23'h0, st_reg.reduced, 5'h0, st_reg.mi_cfg};
        rd[GLB_REDUCED] = st_reg.reduced;
      end else if (haddr[8:5] < 4'(NUM_CH)) begin
        unique case (haddr[4:0])
          OFF_BDP:  rd = st_reg.bdp[haddr[8:5]];
          OFF_CTRL: rd = st_reg.ctrl[haddr[8:5]];
          OFF_STAT: begin
            rd[ST_NC]    = st_reg.done[haddr[8:5]] | st_reg.idone[haddr[8:5]];
            rd[ST_ERR]   = st_reg.err[haddr[8:5]];
            rd[ST_SLEEP] = st_reg.sleep[haddr[8:5]];
            rd[ST_NCIE]  = st_reg.ncie[haddr[8:5]];
            rd[ST_ERRIE] = st_reg.erie[haddr[8:5]];
          end
          default: rd = '0;
        endcase
      end
      st_next.hrdata = rd;
    end
    st_next.hreadyout = 1'b1;
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg           <= '0;
      st_reg.fsm       <= S_IDLE;
      st_reg.hreadyout <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout = st_reg.hreadyout;
  assign hrdata    = st_reg.hrdata;
  assign hresp     = 1'b0;
  assign sys_req   = st_reg.bus;
  assign dack      = st_reg.dack;
  assign frame_end = st_reg.frame_end;
  assign irq       = st_reg.irq;

endmodule : ten_channel_descriptor_dma

/* tb/dma_properties.sv */
`timescale 1ns/1ps
module dma_properties
  import dma_pkg::*;
(
  input wire logic              hclk,
  input wire logic              hresetn,
  input wire logic              hsel,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic              hready,
  input wire logic              hreadyout,
  input wire logic              hresp,
  input wire sysbus_req_t       sys_req,
  input wire sysbus_rsp_t       sys_rsp,
  input wire logic [NUM_CH-1:0] dack,
  input wire logic [NUM_CH-1:0] frame_end
);
  // --------------------------------
  // helper and properties
  // --------------------------------
  logic seen_wr_reg;
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) seen_wr_reg <= 1'b0;
    else if (hsel && hready && htrans[1] && hwrite) seen_wr_reg <= 1'b1;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_zero_wait; hreadyout == 1'b1; endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("wait state inserted");
  property p_idle; !seen_wr_reg |-> !sys_req.req; endproperty
  a_idle: assert property (p_idle) else $error("bus request before setup");
  property p_req_hold; sys_req.req && !sys_rsp.ack |=> sys_req.req && $stable(sys_req.addr); endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped early");
  property p_req_gap; sys_rsp.ack |=> !sys_req.req; endproperty
  a_req_gap: assert property (p_req_gap) else $error("no idle after ack");
  property p_beat; sys_req.req && sys_req.flyby && sys_rsp.ack |-> ##[0:2] (dack != '0); endproperty
  a_beat: assert property (p_beat) else $error("fly-by beat without dack");
  property p_dack_pulse; (dack != '0) |=> ((dack & $past(dack)) == '0); endproperty
  a_dack_pulse: assert property (p_dack_pulse) else $error("dack longer than one cycle");
  property p_one_ch; $onehot0(dack) && $onehot0(frame_end); endproperty
  a_one_ch: assert property (p_one_ch) else $error("two channels served at once");
  property p_frame; (frame_end != '0) |=> ((frame_end & $past(frame_end)) == '0); endproperty
  a_frame: assert property (p_frame) else $error("frame end not a pulse");
endmodule : dma_properties

bind ten_channel_descriptor_dma dma_properties i_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .sys_req(sys_req), .sys_rsp(sys_rsp), .dack(dack), .frame_end(frame_end));

/* tb/sys_mem_model.sv */
`timescale 1ns/1ps
module sys_mem_model
  import dma_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        slow,
  input  wire sysbus_req_t sys_req,
  output sysbus_rsp_t      sys_rsp
);
  logic [31:0] mem [0:255];
  logic [1:0]  wait_cnt;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_cnt <= 2'd0;
      sys_rsp  <= '0;
    end else begin
      sys_rsp.ack   <= 1'b0;
      // released bus never holds its last word
      sys_rsp.rdata <= ~sys_rsp.rdata;
      if (sys_req.req && !sys_rsp.ack) begin
        if (slow && wait_cnt != 2'd3) wait_cnt <= wait_cnt + 2'd1;
        else begin
          wait_cnt    <= 2'd0;
          sys_rsp.ack <= 1'b1;
          if (sys_req.write) mem[sys_req.addr[9:2]] <= sys_req.wdata;
          else sys_rsp.rdata <= mem[sys_req.addr[9:2]];
        end
      end
    end
  end
endmodule : sys_mem_model

/* tb/ten_channel_descriptor_dma_tb.sv */
`timescale 1ns/1ps
module ten_channel_descriptor_dma_tb
  import dma_pkg::*;
;
  logic              hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, reduced_variant, slow, pend;
  logic [31:0]       haddr, hwdata, hrdata, rnd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [NUM_CH-1:0] dreq, rx_done, dack, frame_end;
  logic [3:0]        ext_dreq;
  sysbus_req_t       sys_req;
  sysbus_rsp_t       sys_rsp;
  logic [31:0]       exp_q[$];
  int                fails, tests_run, cyc, n, beats;

  ten_channel_descriptor_dma i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .sys_req(sys_req), .sys_rsp(sys_rsp), .dreq(dreq), .ext_dreq(ext_dreq), .rx_done(rx_done),
    .reduced_variant(reduced_variant), .dack(dack), .frame_end(frame_end), .irq(irq));
  sys_mem_model i_mem (.hclk(hclk), .hresetn(hresetn), .slow(slow), .sys_req(sys_req), .sys_rsp(sys_rsp));

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
    tests_run++;
    if (seen !== expv) begin
      fails++;
      $display("BAD %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : chk

  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    if (!w) exp_q.push_back(e);
    hsel   <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : ahb

  // --------------------------------
  // clock, read monitor, timeout
  // --------------------------------
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  always @(posedge hclk) begin
    if (pend && exp_q.size() > 0) chk(hrdata, exp_q.pop_front());
    pend <= hsel && htrans[1] && !hwrite && hreadyout;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      close_out();
    end
  end

  // --------------------------------
  // scenarios
  // --------------------------------
  initial begin
    hresetn         = 1'b0;
    hsel            = 1'b0;
    haddr           = '0;
    htrans          = 2'b00;
    hwrite          = 1'b0;
    hsize           = 3'b010;
    hwdata          = '0;
    dreq            = '0;
    ext_dreq        = '0;
    rx_done         = '0;
    reduced_variant = 1'b1;
    slow            = 1'b0;
    rnd             = 32'h0000_de90;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_0000, '0, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0010, '0, 32'h0000_0000);
    ahb(1'b0, 32'h0000_01e0, '0, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0140, '0, 32'h0000_0100);
    ahb(1'b1, 32'h0000_0140, 32'h0000_0001, '0);
    ahb(1'b0, 32'h0000_0140, '0, 32'h0000_0101);
    // fly-by read, channel 2, one-descriptor ring
    rnd = xs(rnd);
    i_mem.mem[16] = 32'h0000_0100 | (rnd & 32'h0000_0003);
    i_mem.mem[17] = 32'hb000_0004;
    ahb(1'b1, 32'h0000_0020, 32'h0000_0040, '0);
    ahb(1'b0, 32'h0000_0020, '0, 32'h0000_0040);
    dreq[1] <= 1'b1;
    ahb(1'b1, 32'h0000_0030, 32'h8400_0000, '0);
    for (n = 0; n < 300 && sys_req.req !== 1'b1; n++) @(posedge hclk);
    chk(32'(n >= 13 && n < 300), 32'h0000_0001);
    chk(sys_req.addr, 32'h0000_0040);
    for (n = 0; n < 3000 && frame_end[1] !== 1'b1; n++) @(posedge hclk);
    chk({22'h0, frame_end}, 32'h0000_0002);
    dreq[1] <= 1'b0;
    repeat (4) @(posedge hclk);
    chk(32'(i_mem.mem[17][BD_F]), 32'h0000_0000);
    chk(32'(irq), 32'h0000_0000);
    // fly-by write, channel 1, receive cut short after the first beat
    i_mem.mem[96] = 32'h0000_01c0;
    i_mem.mem[97] = 32'ha000_0010;
    dreq[0] <= 1'b1;
    ahb(1'b1, 32'h0000_0000, 32'h0000_0180, '0);
    ahb(1'b1, 32'h0000_0010, 32'h8000_0000, '0);
    beats = 0;
    for (n = 0; n < 3000 && frame_end[0] !== 1'b1; n++) begin
      @(posedge hclk);
      if (dack[0] === 1'b1) begin
        beats++;
        rx_done[0] <= 1'b1;
      end
    end
    chk(i_mem.mem[97], 32'hb000_0000 | 32'(4 * beats));
    chk(32'(beats > 0 && beats < 4), 32'h0000_0001);
    dreq[0]    <= 1'b0;
    rx_done[0] <= 1'b0;
    // copy on channel 5, held back by a clear full flag first
    rnd = xs(rnd);
    i_mem.mem[48] = rnd;
    i_mem.mem[32] = 32'h0000_00c0;
    i_mem.mem[33] = 32'hc000_0004;
    i_mem.mem[34] = 32'h0000_00e0;
    i_mem.mem[35] = '0;
    i_mem.mem[56] = ~rnd;
    slow <= 1'b1;
    ahb(1'b1, 32'h0000_0080, 32'h0000_0080, '0);
    ahb(1'b1, 32'h0000_0090, 32'h8800_0000, '0);
    repeat (80) @(posedge hclk);
    chk(i_mem.mem[56], ~rnd);
    i_mem.mem[33] = 32'hd000_0004;
    ahb(1'b1, 32'h0000_0094, 32'h0000_0000, '0);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge hclk);
    chk(32'(irq), 32'h0000_0001);
    chk(i_mem.mem[56], rnd);
    close_out();
  end
endmodule : ten_channel_descriptor_dma_tb
